// [common/adc_seq_consts.svh]
// Named addresses, field positions, masks and reset values of the converter control registers.
// Assumes inclusion by bare name from the package and the design file; definitions only.
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// Register byte addresses on the peripheral bus.
`define ADDR_USER_SEQUENCE_SLOTS 32'h40038008
`define ADDR_CHANNEL_ENABLE_SET 32'h40038010
`define ADDR_CHANNEL_ENABLE_CLEAR 32'h40038014
`define ADDR_CHANNEL_ENABLE_STATE 32'h40038018
`define ADDR_LAST_RESULT 32'h40038020
`define ADDR_IRQ_ENABLE_SET 32'h40038024
`define ADDR_IRQ_ENABLE_CLEAR 32'h40038028
`define ADDR_IRQ_ENABLE_STATE 32'h4003802C
`define ADDR_IRQ_FLAGS 32'h40038030

// Implemented channel bits; channels 4 and 5 do not exist.
`define CHANNEL_MASK 8'hCF
// Implemented interrupt bits.
`define IRQ_MASK 32'h1F0800CF

// Interrupt bit positions.
`define BIT_THERMAL_CHANGE 19
`define BIT_RESULT_READY 24
`define BIT_GENERAL_OVERRUN 25
`define BIT_WINDOW_EVENT 26
`define BIT_RECEIVE_DONE 27
`define BIT_RECEIVE_FULL 28

// Last-result field layout.
`define LAST_RESULT_VALUE_LSB 0
`define LAST_RESULT_VALUE_MSB 11
`define LAST_RESULT_SOURCE_LSB 12
`define LAST_RESULT_SOURCE_MSB 15

// Sequence slot field layout: one nibble per slot, index in the low three bits.
`define SLOT_FIELD_WIDTH 4
`define SLOT_INDEX_WIDTH 3

// Reset values.
`define RESET_WORD 32'h00000000
`define RESET_CHANNELS 8'h00
`define RESET_SLOT 3'h0
`endif

// [common/adc_seq_pkg.sv]
// Types shared by the converter control block and its surroundings.
// Assumes the constants header is on the include path.
`include "adc_seq_consts.svh"

package adc_seq_pkg;

    // One finished conversion as reported by the converter core.
    typedef struct packed {
        logic done;       // One-cycle pulse: a conversion has completed.
        logic [2:0] channel;
        logic [11:0] data;
    } conv_result_s;

    // Single-cycle event pulses from the surrounding converter logic.
    typedef struct packed {
        logic thermal_change;
        logic general_overrun;
        logic window_event;
    } conv_events_s;

    // Receive counter status from the transfer controller.
    typedef struct packed {
        logic counter_zero;      // Level: receive counter equals zero.
        logic next_counter_zero; // Level: next-receive counter equals zero.
        logic counter_written;   // Pulse: either counter was written.
    } rx_status_s;

    // Register selected by the current bus address.
    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_SLOTS,
        SEL_CH_SET,
        SEL_CH_CLEAR,
        SEL_CH_STATE,
        SEL_LAST,
        SEL_IRQ_SET,
        SEL_IRQ_CLEAR,
        SEL_IRQ_STATE,
        SEL_IRQ_FLAGS
    } reg_sel_e;

endpackage

// [src/adc_channel_sequence_irq_regs.sv]
// Register-side control of the converter: channel sequence, channel enables, last result capture
// and interrupt flags with mask. Assumes all inputs come from logic on the same clock and that the
// converter core, per-channel result registers and transfer controller live outside this block.
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

// Behaviour
// R1 - Each sequence slot holds a channel index from 0 to 7.
// R2 - Slot fields steer conversion order only while custom order mode is on.
// R3 - A slot joins the sequence only when its enable status bit is one.
// R4 - Repeated channel indices in several slots are each sampled once per sequence.
// R5 - Sequence and channel enable/disable writes are blocked while write lock is on.
// R6 - Writing one to an enable bit enables that channel; zero leaves it alone.
// R7 - In custom order mode enable bit x refers to sequence slot x.
// R8 - Writing one to a disable bit disables that channel; zero leaves it alone.
// R9 - Software must not disable or re-enable a channel during its conversion.
// R10 - Channel status reads one for enabled channels, zero for disabled ones.
// R11 - Every completed conversion loads the last result, held until the next one.
// R12 - Last result source shows the channel when tagging is on, else zero.
// R13 - Writing one to interrupt enable sets the matching mask bit.
// R14 - Writing one to interrupt disable clears the matching mask bit.
// R15 - Mask register reads one for each enabled interrupt source.
// R16 - Done flag x sets on channel x completion, clears on its result read; here it is held at zero while enable bit x is zero.
// R17 - Thermal change flag sets on channel 7 match, clears on flag read.
// R18 - Result ready flag sets on any conversion, clears on last result read.
// R19 - General overrun flag sets on overrun, clears on flag register read.
// R20 - Window event flag sets on comparison event, clears on flag read.
// R21 - Receive done sets when receive counter reaches zero, clears on counter write.
// R22 - Receive full reads one only while both receive counters are zero.
// R23 - Normal mode converts ascending channel order; custom mode follows slot register.
// R24 - Interrupt bits: done 0-3,6,7; thermal 19; ready..full 24 to 28.
// R25 - Channel bits 4 and 5 are reserved, ignore writes, read zero.
// R26 - Interrupt request is high while any flag and its mask are both one.
// R27 - Registers are 32 bits; undefined bits read zero and ignore writes.
module adc_channel_sequence_irq_regs #(
    parameter int NUM_SLOTS = 8 // Sequence positions and channel bits.
) (
    input wire logic clk, // 100 MHz peripheral clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [31:0] address, // Avalon byte address.
    input wire logic read, // Avalon read request.
    input wire logic write, // Avalon write request.
    input wire logic [3:0] byteenable, // Avalon byte lanes of a write.
    input wire logic [31:0] writedata, // Avalon write data.
    output logic [31:0] readdata, // Avalon read data.
    output logic waitrequest, // Avalon wait, low for the answering cycle.
    input wire logic custom_order_on, // Mode register: sequence follows the slots.
    input wire logic write_lock_on, // Write protection of sequence and enables.
    input wire logic tag_on, // Extended mode: tag the last result with its channel.
    input wire adc_seq_pkg::conv_result_s conv_result, // Finished conversion from the core.
    input wire adc_seq_pkg::conv_events_s conv_events, // Thermal, overrun and window pulses.
    input wire adc_seq_pkg::rx_status_s rx_status, // Transfer controller counters.
    input wire logic [7:0] per_channel_result_read, // Pulse: channel x result register read.
    input wire logic seq_start, // Pulse: begin a new conversion sequence.
    input wire logic seq_next, // Pulse: current position converted, move on.
    output logic seq_valid, // A sequence position is pending.
    output logic [2:0] seq_channel, // Physical channel to convert next.
    output logic [7:0] channel_state, // Enabled channels or slots.
    output logic irq // Interrupt request to the processor.
);
    import adc_seq_pkg::*;

    logic [`SLOT_INDEX_WIDTH-1:0] sequence_slot_sel [NUM_SLOTS];
    logic [7:0] channel_bit;
    logic [31:0] irq_enable;
    logic [7:0] conversion_done_flag;
    logic thermal_change_flag;
    logic result_ready_flag;
    logic general_overrun_flag;
    logic window_event_flag;
    logic receive_done_flag;
    logic receive_full_flag;
    logic counter_zero_prev;
    logic [`LAST_RESULT_VALUE_MSB-`LAST_RESULT_VALUE_LSB:0] last_result_value;
    logic [`LAST_RESULT_SOURCE_MSB-`LAST_RESULT_SOURCE_LSB:0] last_result_source;
    logic [2:0] seq_pos;

    reg_sel_e sel;
    logic [31:0] wmask;
    logic [31:0] wdata;
    logic wr_take;
    logic rd_take;
    logic wr_open;
    logic [31:0] flags_word;
    logic [31:0] flags_clr;
    logic [31:0] slots_word;
    logic [31:0] next_readdata;
    logic [7:0] set_bits;
    logic [7:0] clear_bits;
    logic [3:0] next_pos;
    logic [3:0] first_pos;

    // Address decode; anything outside the map selects nothing.
    always_comb begin
        unique case (address)
            `ADDR_USER_SEQUENCE_SLOTS: sel = SEL_SLOTS;
            `ADDR_CHANNEL_ENABLE_SET: sel = SEL_CH_SET;
            `ADDR_CHANNEL_ENABLE_CLEAR: sel = SEL_CH_CLEAR;
            `ADDR_CHANNEL_ENABLE_STATE: sel = SEL_CH_STATE;
            `ADDR_LAST_RESULT: sel = SEL_LAST;
            `ADDR_IRQ_ENABLE_SET: sel = SEL_IRQ_SET;
            `ADDR_IRQ_ENABLE_CLEAR: sel = SEL_IRQ_CLEAR;
            `ADDR_IRQ_ENABLE_STATE: sel = SEL_IRQ_STATE;
            `ADDR_IRQ_FLAGS: sel = SEL_IRQ_FLAGS;
            default: sel = SEL_NONE;
        endcase
    end

    // Byte lanes gate the write data so partial writes touch only their bytes.
    assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign wdata = writedata & wmask;

    // A request takes effect only at the edge where the master sees waitrequest low.
    assign wr_take = write && !waitrequest;
    assign rd_take = read && !waitrequest;
    assign wr_open = wr_take && !write_lock_on; // see R5

    // One wait cycle per access: the answer is registered, so the master
    // always sees waitrequest low exactly one cycle after it raised its request.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // Sequence slot fields; only the three index bits are stored.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                sequence_slot_sel[i] <= `RESET_SLOT;
            end
        end else if (wr_open && sel == SEL_SLOTS) begin // see R5
            for (int i = 0; i < NUM_SLOTS; i++) begin
                if (byteenable[i/2]) begin
                    sequence_slot_sel[i] <= writedata[i*`SLOT_FIELD_WIDTH +: `SLOT_INDEX_WIDTH]; // see R1
                end
            end
        end
    end

    // Field bit 3 of each slot is not stored and reads zero.
    always_comb begin
        slots_word = `RESET_WORD;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            slots_word[i*`SLOT_FIELD_WIDTH +: `SLOT_INDEX_WIDTH] = sequence_slot_sel[i]; // see R1
        end
    end

    // Set and clear views of a channel write; reserved lanes never pass.
    assign set_bits = (wr_open && sel == SEL_CH_SET) ? (wdata[7:0] & `CHANNEL_MASK) : `RESET_CHANNELS;
    assign clear_bits = (wr_open && sel == SEL_CH_CLEAR) ? (wdata[7:0] & `CHANNEL_MASK) : `RESET_CHANNELS;

    // Channel enables. A bit both set and cleared in one cycle cannot happen,
    // since the two writes go to different addresses.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            channel_bit <= `RESET_CHANNELS;
        end else begin
            channel_bit <= ((channel_bit | set_bits) & ~clear_bits) & `CHANNEL_MASK; // see R6 R8 R25
        end
    end

    // Exported copy of the enables; in custom order mode these name slots, not channels.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            channel_state <= `RESET_CHANNELS;
        end else begin
            channel_state <= ((channel_bit | set_bits) & ~clear_bits) & `CHANNEL_MASK; // see R7 R10
        end
    end

    // Interrupt mask with set and clear addresses.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_enable <= `RESET_WORD;
        end else if (wr_take && sel == SEL_IRQ_SET) begin
            irq_enable <= irq_enable | (wdata & `IRQ_MASK); // see R13 R24 R27
        end else if (wr_take && sel == SEL_IRQ_CLEAR) begin
            irq_enable <= irq_enable & ~wdata; // see R14
        end
    end

    // Last result capture, tagged with its channel only when tagging is on.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            last_result_value <= '0;
            last_result_source <= '0;
        end else if (conv_result.done) begin
            last_result_value <= conv_result.data; // see R11
            last_result_source <= tag_on ? {1'b0, conv_result.channel} : 4'h0; // see R12
        end
    end

    // Per-channel done flags. A completion in the same cycle as the result
    // read wins, so no conversion is lost; a disabled channel holds zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conversion_done_flag <= `RESET_CHANNELS;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (!channel_bit[i]) begin
                    conversion_done_flag[i] <= 1'b0; // see R16 R25
                end else if (conv_result.done && conv_result.channel == 3'(i)) begin
                    conversion_done_flag[i] <= 1'b1; // see R16
                end else if (per_channel_result_read[i]) begin
                    conversion_done_flag[i] <= 1'b0; // see R16
                end
            end
        end
    end

    // Result ready: set by any completion, cleared by reading the last result.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_ready_flag <= 1'b0;
        end else if (conv_result.done) begin
            result_ready_flag <= 1'b1; // see R18
        end else if (rd_take && sel == SEL_LAST) begin
            result_ready_flag <= 1'b0; // see R18
        end
    end

    // Event flags clear only where the flag read returned them, so an event in the wait cycle is kept.
    assign flags_clr = (rd_take && sel == SEL_IRQ_FLAGS) ? readdata : `RESET_WORD;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            thermal_change_flag <= 1'b0;
            general_overrun_flag <= 1'b0;
            window_event_flag <= 1'b0;
        end else begin
            thermal_change_flag <= conv_events.thermal_change
                || (thermal_change_flag && !flags_clr[`BIT_THERMAL_CHANGE]); // see R17
            general_overrun_flag <= conv_events.general_overrun
                || (general_overrun_flag && !flags_clr[`BIT_GENERAL_OVERRUN]); // see R19
            window_event_flag <= conv_events.window_event
                || (window_event_flag && !flags_clr[`BIT_WINDOW_EVENT]); // see R20
        end
    end

    // Receive done catches the counter reaching zero, so a counter that merely
    // stays zero after a write does not set it again until it is reloaded.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            counter_zero_prev <= 1'b0;
            receive_done_flag <= 1'b0;
        end else begin
            counter_zero_prev <= rx_status.counter_zero;
            if (rx_status.counter_zero && !counter_zero_prev) begin
                receive_done_flag <= 1'b1; // see R21
            end else if (rx_status.counter_written) begin
                receive_done_flag <= 1'b0; // see R21
            end
        end
    end

    // Receive full follows both counters, one cycle behind them.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            receive_full_flag <= 1'b0;
        end else begin
            receive_full_flag <= rx_status.counter_zero && rx_status.next_counter_zero; // see R22
        end
    end

    // Flag register image in its documented bit positions.
    always_comb begin
        flags_word = `RESET_WORD;
        flags_word[7:0] = conversion_done_flag & `CHANNEL_MASK; // see R24
        flags_word[`BIT_THERMAL_CHANGE] = thermal_change_flag;
        flags_word[`BIT_RESULT_READY] = result_ready_flag;
        flags_word[`BIT_GENERAL_OVERRUN] = general_overrun_flag;
        flags_word[`BIT_WINDOW_EVENT] = window_event_flag;
        flags_word[`BIT_RECEIVE_DONE] = receive_done_flag;
        flags_word[`BIT_RECEIVE_FULL] = receive_full_flag;
    end

    // Interrupt request, registered so the output comes straight from a flop.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags_word & irq_enable); // see R26
        end
    end

    // Read mux; write-only and unmapped addresses read zero.
    always_comb begin
        next_readdata = `RESET_WORD;
        unique case (sel)
            SEL_SLOTS: next_readdata = slots_word;
            SEL_CH_STATE: next_readdata = {24'h000000, channel_bit}; // see R10 R27
            SEL_LAST: begin
                next_readdata[`LAST_RESULT_VALUE_MSB:`LAST_RESULT_VALUE_LSB] = last_result_value; // see R11
                next_readdata[`LAST_RESULT_SOURCE_MSB:`LAST_RESULT_SOURCE_LSB] = last_result_source; // see R12
            end
            SEL_IRQ_STATE: next_readdata = irq_enable; // see R15
            SEL_IRQ_FLAGS: next_readdata = flags_word;
            default: next_readdata = `RESET_WORD;
        endcase
    end

    // Read data is captured when the request is first seen and stands
    // through the cycle in which waitrequest is low.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readdata <= `RESET_WORD;
        end else if (read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

    // Next enabled position at or after a starting point; bit 3 of the
    // result flags that no enabled position remains.
    function automatic logic [3:0] find_pos(input logic [7:0] enabled, input logic [3:0] from);
        logic [3:0] found;
        found = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (enabled[i] && 4'(i) >= from) begin
                found = 4'(i); // see R3
            end
        end
        return found;
    endfunction

    assign first_pos = find_pos(channel_bit, 4'h0);
    assign next_pos = find_pos(channel_bit, {1'b0, seq_pos} + 4'h1);

    // Sequencer walks the enabled positions in ascending order. In custom
    // order mode each position converts its slot's channel, so one channel
    // in several slots is converted once per slot.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seq_pos <= 3'h0;
            seq_valid <= 1'b0;
        end else if (seq_start) begin
            seq_pos <= first_pos[2:0];
            seq_valid <= !first_pos[3];
        end else if (seq_next && seq_valid) begin
            seq_pos <= next_pos[2:0]; // see R4 R23
            seq_valid <= !next_pos[3];
        end
    end

    // Channel of the pending position, mapped through the slots only in custom order mode.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seq_channel <= 3'h0;
        end else if (seq_start) begin
            seq_channel <= custom_order_on ? sequence_slot_sel[first_pos[2:0]] : first_pos[2:0]; // see R2 R7
        end else if (seq_next && seq_valid) begin
            seq_channel <= custom_order_on ? sequence_slot_sel[next_pos[2:0]] : next_pos[2:0]; // see R2 R23
        end
    end

endmodule

// [verification/adc_regs_sva.sv]
// Checker for the converter control block: bus timing, channel enables and sequencer.
// Assumes it is bound to the block and sees only the block's ports.
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module adc_regs_sva (
    input wire logic clk, // Clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [31:0] address, // Bus address.
    input wire logic read, // Bus read.
    input wire logic write, // Bus write.
    input wire logic [3:0] byteenable, // Byte lanes.
    input wire logic [31:0] writedata, // Write data.
    input wire logic waitrequest, // Bus wait.
    input wire logic write_lock_on, // Write protection.
    input wire logic seq_start, // Sequence start pulse.
    input wire logic seq_valid, // Position pending.
    input wire logic [7:0] channel_state // Enable bits.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic ch_wr;
    // An unlocked committed write with the enable byte lane on.
    assign ch_wr = write && !waitrequest && byteenable[0] && !write_lock_on;
    chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("access not answered after one wait cycle");
    chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_wait_cause: assert property (!waitrequest |-> $past(read || write))
        else $error("answer without a request");
    chk_reserved_bits: assert property (channel_state[5:4] == 2'h0)
        else $error("reserved channel bits set");
    chk_lock_hold: assert property (write && !waitrequest && write_lock_on |=> $stable(channel_state))
        else $error("locked write changed enables");
    chk_set_bits: assert property (ch_wr && address == `ADDR_CHANNEL_ENABLE_SET |=>
        channel_state == ($past(channel_state) | ($past(writedata[7:0]) & `CHANNEL_MASK)))
        else $error("enable set write wrong");
    chk_clear_bits: assert property (ch_wr && address == `ADDR_CHANNEL_ENABLE_CLEAR |=>
        channel_state == ($past(channel_state) & ~$past(writedata[7:0])))
        else $error("enable clear write wrong");
    chk_seq_idle: assert property (!seq_valid && !seq_start |=> !seq_valid)
        else $error("sequence advanced while idle");
    chk_seq_begin: assert property (seq_start && channel_state != 8'h00 && !write |=> seq_valid)
        else $error("sequence did not start");
endmodule

bind adc_channel_sequence_irq_regs adc_regs_sva u_chk (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .waitrequest(waitrequest),
    .write_lock_on(write_lock_on), .seq_start(seq_start), .seq_valid(seq_valid), .channel_state(channel_state));

// [verification/tb.sv]
// Self-checking bench for the converter control block, driving every port directly.
// Assumes the package and constants header are compiled first; the checker binds itself.
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module tb;
    import adc_seq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] address = 32'h0, writedata = 32'h0, readdata, rd;
    logic read = 1'b0, write = 1'b0, waitrequest, lock = 1'b0, tag = 1'b0, cust = 1'b0;
    logic seq_start = 1'b0, seq_next = 1'b0, seq_valid, irq;
    logic [2:0] seq_channel;
    logic [7:0] channel_state, pcr = 8'h00;
    conv_result_s conv = '0;
    conv_events_s ev = '0;
    rx_status_s rx = '0;
    int error_cnt = 0;
    int compares = 0;
    // Free-running 100 MHz clock.
    always #5 clk = ~clk;
    adc_channel_sequence_irq_regs u_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .custom_order_on(cust), .write_lock_on(lock), .tag_on(tag),
        .conv_result(conv), .conv_events(ev), .rx_status(rx), .per_channel_result_read(pcr),
        .seq_start(seq_start), .seq_next(seq_next), .seq_valid(seq_valid), .seq_channel(seq_channel),
        .channel_state(channel_state), .irq(irq));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus access; the request is held until waitrequest is sampled low, with a bounded wait.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rd = readdata;
        if (n >= 20) begin
            error_cnt++;
            $display("Error at %0t: bus hung", $time);
        end
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // Starts a sequence and follows it through three positions, then expects it to end.
    task automatic run_seq(input logic [2:0] exp [3]);
        @(posedge clk);
        seq_start <= 1'b1;
        @(posedge clk);
        seq_start <= 1'b0;
        seq_next <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            #1;
            check(seq_valid, 32'h1);
            check(seq_channel, exp[i]);
            @(posedge clk);
        end
        seq_next <= 1'b0;
        #1;
        check(seq_valid, 32'h0);
    endtask
    task automatic test_reset;
        logic [31:0] adr [6];
        adr = '{`ADDR_USER_SEQUENCE_SLOTS, `ADDR_CHANNEL_ENABLE_STATE, `ADDR_LAST_RESULT,
            `ADDR_IRQ_ENABLE_STATE, `ADDR_IRQ_FLAGS, `ADDR_CHANNEL_ENABLE_SET};
        foreach (adr[i]) rdchk(adr[i], 32'h0);
        rdchk(32'h4003801C, 32'h0);
        $display("test_reset finished");
    endtask
    task automatic test_enables;
        bus(1'b1, `ADDR_CHANNEL_ENABLE_SET, 32'hFFFFFFFF);
        rdchk(`ADDR_CHANNEL_ENABLE_STATE, 32'hCF);
        bus(1'b1, `ADDR_CHANNEL_ENABLE_CLEAR, 32'h3);
        bus(1'b1, `ADDR_CHANNEL_ENABLE_SET, 32'h0);
        bus(1'b1, `ADDR_CHANNEL_ENABLE_CLEAR, 32'h0);
        rdchk(`ADDR_CHANNEL_ENABLE_STATE, 32'hCC);
        check(channel_state, 32'hCC);
        $display("test_enables finished");
    endtask
    // Protected writes are answered but must leave slots and enables alone.
    task automatic test_lock;
        @(posedge clk);
        lock <= 1'b1;
        bus(1'b1, `ADDR_CHANNEL_ENABLE_SET, 32'h33);
        bus(1'b1, `ADDR_CHANNEL_ENABLE_CLEAR, 32'hCC);
        bus(1'b1, `ADDR_USER_SEQUENCE_SLOTS, 32'hFFFFFFFF);
        rdchk(`ADDR_CHANNEL_ENABLE_STATE, 32'hCC);
        rdchk(`ADDR_USER_SEQUENCE_SLOTS, 32'h0);
        lock <= 1'b0;
        $display("test_lock finished");
    endtask
    task automatic test_sequence;
        bus(1'b1, `ADDR_USER_SEQUENCE_SLOTS, 32'hFFFFFFFF);
        rdchk(`ADDR_USER_SEQUENCE_SLOTS, 32'h77777777);
        bus(1'b1, `ADDR_CHANNEL_ENABLE_CLEAR, 32'hFF);
        bus(1'b1, `ADDR_CHANNEL_ENABLE_SET, 32'h43);
        bus(1'b1, `ADDR_USER_SEQUENCE_SLOTS, 32'h07000022);
        @(posedge clk);
        cust <= 1'b1;
        run_seq('{3'h2, 3'h2, 3'h7});
        @(posedge clk);
        cust <= 1'b0;
        run_seq('{3'h0, 3'h1, 3'h6});
        $display("test_sequence finished");
    endtask
    task automatic test_conv;
        @(posedge clk);
        tag <= 1'b1;
        bus(1'b1, `ADDR_IRQ_ENABLE_SET, 32'h01000041);
        rdchk(`ADDR_IRQ_ENABLE_STATE, 32'h01000041);
        @(posedge clk);
        conv <= '{1'b1, 3'h6, 12'hABC};
        @(posedge clk);
        conv <= '0;
        rdchk(`ADDR_IRQ_FLAGS, 32'h01000040);
        check(irq, 32'h1);
        rdchk(`ADDR_LAST_RESULT, 32'h00006ABC);
        rdchk(`ADDR_IRQ_FLAGS, 32'h40);
        pcr <= 8'h40;
        @(posedge clk);
        pcr <= 8'h00;
        rdchk(`ADDR_IRQ_FLAGS, 32'h0);
        check(irq, 32'h0);
        tag <= 1'b0;
        conv <= '{1'b1, 3'h2, 12'h123};
        @(posedge clk);
        conv <= '0;
        rdchk(`ADDR_IRQ_FLAGS, 32'h01000000);
        rdchk(`ADDR_LAST_RESULT, 32'h123);
        bus(1'b1, `ADDR_IRQ_ENABLE_CLEAR, 32'h01000000);
        rdchk(`ADDR_IRQ_ENABLE_STATE, 32'h41);
        $display("test_conv finished");
    endtask
    // Sticky events clear on a status read; receive flags follow the counters.
    task automatic test_events;
        @(posedge clk);
        ev <= 3'h7;
        @(posedge clk);
        ev <= 3'h0;
        rdchk(`ADDR_IRQ_FLAGS, 32'h06080000);
        rdchk(`ADDR_IRQ_FLAGS, 32'h0);
        rx <= '{1'b1, 1'b1, 1'b0};
        repeat (2) @(posedge clk);
        rdchk(`ADDR_IRQ_FLAGS, 32'h18000000);
        rx <= '{1'b1, 1'b0, 1'b1};
        @(posedge clk);
        rx.counter_written <= 1'b0;
        rdchk(`ADDR_IRQ_FLAGS, 32'h0);
        $display("test_events finished");
    endtask
    task automatic finish_test;
        $display("Counts: %0d compares, %0d errors", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence after ten cycles of reset.
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        test_reset();
        test_enables();
        test_lock();
        test_sequence();
        test_conv();
        test_events();
        finish_test();
    end
    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
